// file: src/cfp_core_regs.sv
/*
 flag register, reset cause, oscillator trim and program counter load.
 assumes apb master on pclk; event inputs are one-cycle pulses on pclk;
 power-on and brown-out indications are synchronous pulses from the
 supervisor on the same clock.
*/
// The APB register port was decided locally.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Operation
// - flags set by their event regardless of any enable bit
// - bit 7 sets on eeprom write done, stays until cleared
// - bit 6 sets on conversion done when converter present
// - bit 3 sets on comparator change, holds until cleared
// - bit 0 sets on timer1 overflow, holds until cleared
// - unused flag and reset cause bits read zero, ignore writes
// - power-on clears bits 1 and 0; software writes them to one
// - brown-out clears bit 0; software writes it to one
// - trim register gives six-bit oscillator adjustment
// - trim all ones max, 100000 centre, zeros min, signed
// - trim bits 1-0 read zero and ignore writes
// - pc is 13 bits; low byte readable and writable
// - upper pc bits loaded from the high latch, except bits 10:8 from jump_target on a jump
// - every reset clears the whole pc
// - low byte write copies latch bits 4:0 into upper pc
// - call or goto takes latch bits 4:3 into top pc bits
// - flag interrupts only with own, peripheral, global enables
module cfp_core_regs #(
   parameter bit HAS_CONVERTER = 1'b1
) (
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // events
   input  wire logic        ee_write_done,
   input  wire logic        conversion_done,
   input  wire logic        comparator_change,
   input  wire logic        timer1_overflow,
   input  wire logic        por_event,
   input  wire logic        brownout_event,
   // core pc control
   input  wire logic        pc_step,
   input  wire logic        jump_load,
   input  wire logic [10:0] jump_target,
   // outputs
   output logic [5:0]       trim_value,
   output logic signed [5:0] trim_offset,
   output logic [12:0]      pc_out,
   output logic             periph_irq
);

   //////////////////////////////////////////////////////////////////////////
   logic [7:0]  flags_q;
   logic [7:0]  rcause_q;
   logic [7:0]  trim_q;
   logic [4:0]  hlat_q;
   logic [7:0]  irqen_q;
   logic [7:0]  irqctl_q;
   logic [12:0] pc_q;
   logic [12:0] pc_d;
   logic [7:0]  idx;
   logic        acc;
   logic        wr;
   logic        hit;
   logic [7:0]  wd;
   logic [7:0]  ev;
   logic [7:0]  rd_d;

   function automatic logic sel_idx(input logic [7:0] a,
                                    input logic [7:0] b);
      return a == b;
   endfunction

   assign idx = paddr[9:2];
   assign acc = psel & penable;
   assign wr  = acc & pwrite;
   assign wd  = pwdata[7:0];
   assign hit = sel_idx(idx, cfp_pkg::IDX_FLAGS)
              | sel_idx(idx, cfp_pkg::IDX_RCAUSE)
              | sel_idx(idx, cfp_pkg::IDX_TRIM)
              | sel_idx(idx, cfp_pkg::IDX_PCLOW)
              | sel_idx(idx, cfp_pkg::IDX_PCHLAT)
              | sel_idx(idx, cfp_pkg::IDX_IRQEN)
              | sel_idx(idx, cfp_pkg::IDX_IRQCTL)
              | sel_idx(idx, cfp_pkg::IDX_PCFULL);

   //////////////////////////////////////////////////////////////////////////
   // flags: hardware set beats software clear
   always_comb begin
      ev = '0;
      ev[cfp_pkg::BIT_EE] = ee_write_done;
      ev[cfp_pkg::BIT_AD] = conversion_done & HAS_CONVERTER;
      ev[cfp_pkg::BIT_CM] = comparator_change;
      ev[cfp_pkg::BIT_T1] = timer1_overflow;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= '0;
      end else if (wr && sel_idx(idx, cfp_pkg::IDX_FLAGS)) begin
         // set wins over the clear; unused bits stay zero
         flags_q <= ((wd | ev) & cfp_pkg::FLAG_MASK);
      end else begin
         flags_q <= (flags_q | ev) & cfp_pkg::FLAG_MASK;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // reset cause; brown-out bit powers up unknown, modelled as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rcause_q <= cfp_pkg::RCAUSE_RST;
      end else begin
         if (wr && sel_idx(idx, cfp_pkg::IDX_RCAUSE)) begin
            rcause_q <= wd & cfp_pkg::RCAUSE_MASK;
         end
         if (por_event) begin
            rcause_q[cfp_pkg::BIT_POR] <= 1'b0;
            rcause_q[cfp_pkg::BIT_BROWNOUT] <= 1'b0;
         end
         if (brownout_event) begin
            rcause_q[cfp_pkg::BIT_BROWNOUT] <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // trim
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_q <= cfp_pkg::TRIM_RST;
      end else if (wr && sel_idx(idx, cfp_pkg::IDX_TRIM)) begin
         trim_q <= wd & cfp_pkg::TRIM_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_value  <= cfp_pkg::TRIM_RST[7:2];
         trim_offset <= '0;
      end else begin
         trim_value  <= trim_q[7:2];
         // offset binary: flip the top bit to get two's complement
         trim_offset <= {~trim_q[7], trim_q[6:2]};
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // enables, high latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irqen_q  <= '0;
         irqctl_q <= '0;
         hlat_q   <= '0;
      end else if (wr) begin
         if (sel_idx(idx, cfp_pkg::IDX_IRQEN)) begin
            irqen_q <= wd & cfp_pkg::FLAG_MASK;
         end
         if (sel_idx(idx, cfp_pkg::IDX_IRQCTL)) begin
            irqctl_q <= wd & cfp_pkg::IRQCTL_MASK;
         end
         if (sel_idx(idx, cfp_pkg::IDX_PCHLAT)) begin
            hlat_q <= wd[4:0] & cfp_pkg::HLAT_MASK;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_irq <= 1'b0;
      end else begin
         periph_irq <= (|(flags_q & irqen_q))
                     & irqctl_q[cfp_pkg::BIT_PERIPH_EN]
                     & irqctl_q[cfp_pkg::BIT_GLOBAL_EN];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // program counter; the add does not touch the latch, so table
   // jumps across a 256 block need software to set the latch first
   always_comb begin
      pc_d = pc_q;
      if (wr && sel_idx(idx, cfp_pkg::IDX_PCLOW)) begin
         pc_d = {hlat_q, wd};
      end else if (jump_load) begin
         pc_d = {hlat_q[4:3], jump_target};
      end else if (pc_step) begin
         pc_d = pc_q + 13'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q <= '0;
      end else begin
         pc_q <= pc_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_out <= '0;
      end else begin
         pc_out <= pc_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // apb answer: no wait state, read data registered
   always_comb begin
      rd_d = '0;
      unique case (1'b1)
         sel_idx(idx, cfp_pkg::IDX_FLAGS):  rd_d = flags_q;
         sel_idx(idx, cfp_pkg::IDX_RCAUSE): rd_d = rcause_q;
         sel_idx(idx, cfp_pkg::IDX_TRIM):   rd_d = trim_q;
         sel_idx(idx, cfp_pkg::IDX_PCLOW):  rd_d = pc_q[7:0];
         sel_idx(idx, cfp_pkg::IDX_PCHLAT): rd_d = {3'b000, hlat_q};
         sel_idx(idx, cfp_pkg::IDX_IRQEN):  rd_d = irqen_q;
         sel_idx(idx, cfp_pkg::IDX_IRQCTL): rd_d = irqctl_q;
         default:                           rd_d = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         prdata  <= {24'h0000_00, rd_d};
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // assertions
   // the pc low write and the load it causes are one cycle apart;
   // named so the property reads in the order the hardware acts
   sequence s_pcl_write;
      wr && sel_idx(idx, cfp_pkg::IDX_PCLOW);
   endsequence

   sequence s_pcl_load;
      pc_q == {$past(hlat_q), $past(wd)};
   endsequence

   AST_FLAG_HOLD: assert property (
      @(posedge pclk) disable iff (!presetn)
      flags_q[cfp_pkg::BIT_EE] && !wr |=> flags_q[cfp_pkg::BIT_EE])
      else $error("eeprom flag dropped without write");
   AST_EE_SET: assert property (
      @(posedge pclk) disable iff (!presetn)
      ee_write_done |=> flags_q[cfp_pkg::BIT_EE])
      else $error("eeprom event lost");
   AST_AD_SET: assert property (
      @(posedge pclk) disable iff (!presetn)
      conversion_done && HAS_CONVERTER |=> flags_q[cfp_pkg::BIT_AD])
      else $error("conversion event lost");
   AST_CM_SET: assert property (
      @(posedge pclk) disable iff (!presetn)
      comparator_change |=> flags_q[cfp_pkg::BIT_CM])
      else $error("comparator event lost");
   AST_T1_SET: assert property (
      @(posedge pclk) disable iff (!presetn)
      timer1_overflow |=> flags_q[cfp_pkg::BIT_T1])
      else $error("timer1 event lost");
   AST_UNUSED: assert property (
      @(posedge pclk) disable iff (!presetn)
      (flags_q & ~cfp_pkg::FLAG_MASK) == '0
      && (rcause_q & ~cfp_pkg::RCAUSE_MASK) == '0)
      else $error("unused bits set");

   AST_POR: assert property (
      @(posedge pclk) disable iff (!presetn)
      por_event |=> !rcause_q[cfp_pkg::BIT_POR])
      else $error("power-on not recorded");
   AST_BROWNOUT: assert property (
      @(posedge pclk) disable iff (!presetn)
      brownout_event |=> !rcause_q[cfp_pkg::BIT_BROWNOUT])
      else $error("brown-out not recorded");
   AST_RCAUSE_WR: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr && sel_idx(idx, cfp_pkg::IDX_RCAUSE)
      && !por_event && !brownout_event
      |=> rcause_q == ($past(wd) & cfp_pkg::RCAUSE_MASK))
      else $error("reset cause write wrong");

   AST_TRIM_VAL: assert property (
      @(posedge pclk) disable iff (!presetn)
      trim_value == $past(trim_q[7:2]))
      else $error("trim value not from trim register");
   AST_TRIM_OFS: assert property (
      @(posedge pclk) disable iff (!presetn)
      trim_offset == $signed($past(trim_q[7:2])
                             - cfp_pkg::TRIM_RST[7:2]))
      else $error("trim offset not centred");
   AST_TRIM_LOW: assert property (
      @(posedge pclk) disable iff (!presetn)
      trim_q[1:0] == 2'b00)
      else $error("trim low bits set");

   AST_PC_STEP: assert property (
      @(posedge pclk) disable iff (!presetn)
      pc_step && !jump_load && !(wr && sel_idx(idx, cfp_pkg::IDX_PCLOW))
      |=> pc_q == $past(pc_q) + 13'h0001)
      else $error("pc step wrong");
   AST_PC_HOLD: assert property (
      @(posedge pclk) disable iff (!presetn)
      !pc_step && !jump_load && !(wr && sel_idx(idx, cfp_pkg::IDX_PCLOW))
      |=> $stable(pc_q))
      else $error("pc changed without a load");
   AST_PC_RST: assert property (
      @(posedge pclk)
      $rose(presetn) |-> pc_q == '0)
      else $error("pc not cleared by reset");
   AST_PCL_WR: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_pcl_write |=> s_pcl_load)
      else $error("pc low write load wrong");
   AST_JUMP: assert property (
      @(posedge pclk) disable iff (!presetn)
      jump_load && !(wr && sel_idx(idx, cfp_pkg::IDX_PCLOW))
      |=> pc_q == {$past(hlat_q[4:3]), $past(jump_target)})
      else $error("jump load wrong");

   AST_IRQ: assert property (
      @(posedge pclk) disable iff (!presetn)
      periph_irq |-> $past(irqctl_q[cfp_pkg::BIT_GLOBAL_EN]))
      else $error("irq without global enable");
   AST_IRQ_SRC: assert property (
      @(posedge pclk) disable iff (!presetn)
      periph_irq |-> $past(irqctl_q[cfp_pkg::BIT_PERIPH_EN])
      && $past(|(flags_q & irqen_q)))
      else $error("irq without enabled flag");

endmodule // cfp_core_regs

// file: src/cfp_pkg.sv
/*
 core flag, reset cause, trim and pc load constants.
 assumes an apb slave with 32-bit data, one register per word.
*/
package cfp_pkg;
   // printed offsets are not all multiples of four: kept as indices
   localparam logic [7:0] IDX_FLAGS   = 8'h0c;
   localparam logic [7:0] IDX_RCAUSE  = 8'h8e;
   localparam logic [7:0] IDX_TRIM    = 8'h90;
   localparam logic [7:0] IDX_PCLOW   = 8'h02;
   localparam logic [7:0] IDX_PCHLAT  = 8'h0a;
   localparam logic [7:0] IDX_IRQEN   = 8'h8c;
   localparam logic [7:0] IDX_IRQCTL  = 8'h0b;
   localparam logic [7:0] IDX_PCFULL  = 8'hf0;
   // field layouts
   localparam int BIT_EE   = 7;
   localparam int BIT_AD   = 6;
   localparam int BIT_CM   = 3;
   localparam int BIT_T1   = 0;
   localparam int BIT_POR  = 1;
   localparam int BIT_BROWNOUT  = 0;
   localparam int BIT_GLOBAL_EN = 7;
   localparam int BIT_PERIPH_EN = 6;
   localparam logic [7:0] FLAG_MASK   = 8'hc9;
   localparam logic [7:0] RCAUSE_MASK = 8'h03;
   localparam logic [7:0] TRIM_MASK   = 8'hfc;
   localparam logic [7:0] IRQCTL_MASK = 8'hc0;
   localparam logic [4:0] HLAT_MASK   = 5'h1f;
   // reset values and pc width
   localparam logic [7:0] TRIM_RST    = 8'h80;
   localparam logic [7:0] RCAUSE_RST  = 8'h00;
   localparam int PC_W = 13;
endpackage

// file: verification/tb_core_flags_status_pc_load.sv
/*
 self-checking bench for the flag, reset cause, trim and pc load block.
 assumes cfp_pkg and cfp_core_regs are compiled before this file.
*/
`timescale 1ns/1ps
module tb_core_flags_status_pc_load;
   logic        pclk        = 1'b0;
   logic        presetn     = 1'b0;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [11:0] paddr       = 12'h000;
   logic [31:0] pwdata      = 32'h0000_0000;
   logic [5:0]  ev          = 6'h00;
   logic        pc_step     = 1'b0;
   logic        jump_load   = 1'b0;
   logic [10:0] jump_target = 11'h000;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic [5:0]  trim_value;
   logic signed [5:0] trim_offset;
   logic [12:0] pc_out;
   logic        periph_irq;
   logic [31:0] rd;
   logic        err;
   int          failures    = 0;
   int          n_compared  = 0;
   logic [7:0]  fbit [4]    = '{8'h80, 8'h40, 8'h08, 8'h01};
   logic [7:0]  tv [3]      = '{8'hff, 8'h00, 8'h81};
   logic [5:0]  toff [3]    = '{6'h1f, 6'h20, 6'h00};

   always #2.5 pclk = ~pclk;

   // ev: 5 por, 4 brown-out, 3 eeprom, 2 conversion, 1 comparator, 0 timer
   cfp_core_regs cfp_core_regs_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .ee_write_done(ev[3]),
      .conversion_done(ev[2]), .comparator_change(ev[1]),
      .timer1_overflow(ev[0]), .por_event(ev[5]), .brownout_event(ev[4]),
      .pc_step(pc_step), .jump_load(jump_load), .jump_target(jump_target),
      .trim_value(trim_value), .trim_offset(trim_offset), .pc_out(pc_out),
      .periph_irq(periph_irq));

   ///////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; waits for pready, only the watchdog ends a wait
   task automatic apb(input logic w, input logic [7:0] idx, d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk("access cycles", 32'h0000_0001, n);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] idx, exp, input string what);
      apb(1'b0, idx, 8'h00);
      chk(what, exp, rd);
   endtask

   task automatic pulse(input logic [5:0] m);
      @(posedge pclk);
      ev <= m;
      @(posedge pclk);
      ev <= 6'h00;
      @(negedge pclk);
   endtask

   ///////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      @(negedge pclk);
      chk("trim_value", 6'h20, trim_value);
      chk("trim_offset", 6'h00, $unsigned(trim_offset));
      chk("pc_out", 13'h0000, pc_out);
      rchk(cfp_pkg::IDX_FLAGS, 8'h00, "flags");
      rchk(cfp_pkg::IDX_TRIM, 8'h80, "trim");
   endtask

   task automatic t_flags;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, cfp_pkg::IDX_FLAGS, 8'h00);
         pulse(6'h08 >> i);
         rchk(cfp_pkg::IDX_FLAGS, fbit[i], "flag set");
         repeat (3) @(posedge pclk);
         rchk(cfp_pkg::IDX_FLAGS, fbit[i], "flag held");
      end
      apb(1'b1, cfp_pkg::IDX_FLAGS, 8'hff);
      rchk(cfp_pkg::IDX_FLAGS, 8'hc9, "flag mask");
      apb(1'b1, cfp_pkg::IDX_FLAGS, 8'h00);
      // clearing write and timer event meet at the same access edge
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= 1'b1;
      paddr  <= {2'b00, cfp_pkg::IDX_FLAGS, 2'b00};
      pwdata <= 32'h0000_0000;
      @(posedge pclk);
      penable <= 1'b1;
      ev      <= 6'h01;
      @(posedge pclk);
      chk("pready same edge", 1'b1, pready);
      psel    <= 1'b0;
      penable <= 1'b0;
      ev      <= 6'h00;
      rchk(cfp_pkg::IDX_FLAGS, 8'h01, "flag kept");
   endtask

   task automatic t_rcause;
      apb(1'b1, cfp_pkg::IDX_RCAUSE, 8'hff);
      rchk(cfp_pkg::IDX_RCAUSE, 8'h03, "rcause mask");
      pulse(6'h20);
      rchk(cfp_pkg::IDX_RCAUSE, 8'h00, "rcause por");
      apb(1'b1, cfp_pkg::IDX_RCAUSE, 8'h03);
      pulse(6'h10);
      rchk(cfp_pkg::IDX_RCAUSE, 8'h02, "rcause bod");
   endtask

   task automatic t_trim;
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, cfp_pkg::IDX_TRIM, tv[i]);
         // trim outputs follow the trim register one cycle later
         repeat (2) @(negedge pclk);
         chk("trim_value", tv[i][7:2], trim_value);
         chk("trim_offset", toff[i], $unsigned(trim_offset));
         rchk(cfp_pkg::IDX_TRIM, tv[i] & 8'hfc, "trim read");
      end
   endtask

   task automatic t_pc;
      apb(1'b1, cfp_pkg::IDX_PCHLAT, 8'hff);
      apb(1'b1, cfp_pkg::IDX_PCLOW, 8'h34);
      @(negedge pclk);
      chk("pc_out low write", 13'h1f34, pc_out);
      rchk(cfp_pkg::IDX_PCLOW, 8'h34, "pc low");
      apb(1'b1, cfp_pkg::IDX_PCHLAT, 8'h15);
      @(negedge pclk);
      chk("pc_out latch only", 13'h1f34, pc_out);
      rchk(cfp_pkg::IDX_PCHLAT, 8'h15, "latch read");
      @(posedge pclk);
      jump_load   <= 1'b1;
      jump_target <= 11'h123;
      @(posedge pclk);
      jump_load <= 1'b0;
      @(negedge pclk);
      chk("pc_out jump", 13'h1123, pc_out);
      @(posedge pclk);
      pc_step <= 1'b1;
      repeat (3) @(posedge pclk);
      pc_step <= 1'b0;
      @(negedge pclk);
      chk("pc_out step", 13'h1126, pc_out);
      // table jump: latch already set by software, then the low byte
      apb(1'b1, cfp_pkg::IDX_PCLOW, 8'h05);
      @(negedge pclk);
      chk("pc_out table jump", 13'h1505, pc_out);
      apb(1'b0, cfp_pkg::IDX_PCFULL, 8'h00);
      chk("pc hidden data", 32'h0000_0000, rd);
      chk("pc hidden err", 1'b0, err);
      apb(1'b0, 8'h55, 8'h00);
      chk("unmapped err", 1'b1, err);
      chk("unmapped data", 32'h0000_0000, rd);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("pc_out reset", 13'h0000, pc_out);
   endtask

   task automatic t_irq;
      apb(1'b1, cfp_pkg::IDX_FLAGS, 8'h00);
      apb(1'b1, cfp_pkg::IDX_IRQEN, 8'h01);
      apb(1'b1, cfp_pkg::IDX_IRQCTL, 8'hc0);
      repeat (2) @(negedge pclk);
      chk("irq idle", 1'b0, periph_irq);
      pulse(6'h01);
      @(negedge pclk);
      chk("irq on", 1'b1, periph_irq);
      apb(1'b1, cfp_pkg::IDX_IRQCTL, 8'h80);
      repeat (2) @(negedge pclk);
      chk("irq masked", 1'b0, periph_irq);
      rchk(cfp_pkg::IDX_IRQCTL, 8'h80, "irq ctl read");
      rchk(cfp_pkg::IDX_IRQEN, 8'h01, "irq enable read");
   endtask

   ///////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_flags();
      t_rcause();
      t_trim();
      t_pc();
      t_irq();
      finish_test();
   end

   // the whole run needs well under 1000 cycles
   initial begin
      #20000;
      failures++;
      $display("mismatch watchdog expected done seen timeout");
      finish_test();
   end
endmodule // tb_core_flags_status_pc_load
